/* File: crs_core_register_set.sv */
// Purpose: Architectural register set of the processor core
// Assumes: Single clock; vector reads answer in one cycle
// Notes: Selector codes in crs_defines.svh
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.svh"

// Contract
// - Thirteen 32-bit general registers
// - Register 13 picks main or process stack
// - Main stack loaded from word at zero
// - Link register resets to 0x0FFFFFFF
// - Program counter bit zero always zero
// - Program counter loaded from reset vector
// - Status word merges three disjoint views
// - Views reachable alone or combined, masks
// - Writes to exception number discarded
// - Execution bits read zero, ignore writes
// - Negative flag follows result sign
// - Zero flag follows zero result
// - Carry flag follows carry or no-borrow
// - Overflow flag follows overflow
// - Saturation flag sticky until software clears
// - Exception number holds active exception
// - Execution view has state bit, block state
// - Interrupted multiple saves next register
// - Continuable state keeps other bits zero
// - Conditional block covers up to four
// - Priority mask blocks configurable exceptions
// - Masks via moves and state change
module crs_core_register_set (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic [31:0] i_vec_data,
	input wire logic i_vec_valid,
	input wire logic i_sp_select,
	input wire logic i_rd_en,
	input wire logic [4:0] i_rd_sel,
	input wire logic i_wr_en,
	input wire logic [4:0] i_wr_sel,
	input wire logic [31:0] i_wr_data,
	input wire logic i_pc_we,
	input wire logic [31:0] i_pc_data,
	input wire logic i_flags_we,
	input wire logic [3:0] i_flags_nzcv,
	input wire logic i_sat_event,
	input wire logic i_exnum_we,
	input wire logic [8:0] i_exnum,
	input wire logic i_ici_save,
	input wire logic [3:0] i_ici_reg,
	input wire logic i_ici_clear,
	input wire logic i_cond_we,
	input wire logic [7:0] i_cond_state,
	input wire logic i_cps_we,
	input wire logic i_cps_val,
	input wire logic i_cfg_exc_req,
	output logic [31:0] o_vec_addr,
	output logic o_vec_req,
	output logic o_ready,
	output logic [31:0] o_rd_data,
	output logic [31:0] o_pc,
	output logic [31:0] o_sp,
	output logic [31:0] o_psr_stacked,
	output logic o_cfg_exc_allow
);

	//--------------------------------------------------
	// Storage
	//--------------------------------------------------
	crs_pkg::crs_state_t state_q;
	crs_pkg::crs_state_t state_d;
	logic [31:0] gpr_q [0:12];
	logic [31:0] msp_q;
	logic [31:0] psp_q;
	logic [31:0] lr_q;
	logic [31:0] pc_q;
	logic [3:0] nzcv_q;
	logic sat_q;
	logic [8:0] exnum_q;
	logic [5:0] exec_hi_q;
	logic exec_t_q;
	logic [1:0] exec_lo_q;
	logic mask_q;

	//--------------------------------------------------
	// Selector map
	//--------------------------------------------------
	// Codes 00 to 0C: general registers zero to twelve
	// Code 0D: stack pointer in use, main or process
	// Code 0E: link register
	// Code 0F: program counter, bit zero always clear
	// Code 10: main stack pointer
	// Code 11: process stack pointer
	// Code 12: configurable exception mask, bit zero only
	// Code 13: combined status word, all three views
	// Code 14: execution plus number view, read only
	// Code 15: flags plus number view
	// Code 16: flags plus execution view
	// Code 17: condition flags view alone
	// Code 18: execution state view alone, reads zero
	// Code 19: exception number view alone, read only
	// Codes 1A to 1F: unmapped, read zero, writes dropped
	// Flags part of a write: data bits 31 to 27
	// Number part of a write: always dropped
	// Execution part of a write: always dropped
	// Execution part of a read: always zero
	// Stacked word output: real execution bits shown
	// Stack pointers: low two bits always stored clear
	// Program counter: low bit always stored clear
	// Link register: no alignment applied
	// Mask: upper thirty-one bits read zero
	// Reads: allowed during boot, answer one edge later
	// Writes: ignored until both vectors taken
	// Read data: holds until the next read strobe

	// Boot sequence summary
	// First edge after release: vector request raised
	// Request address zero: word goes to main stack
	// Then address four: word goes to program counter
	// Ready raised at the edge taking the second word
	// Vector valid outside a fetch: simply ignored
	// Reset again mid-run: boot starts over from zero
	// General registers: cleared by reset for determinism
	// Process stack: cleared by reset as well
	// Execution state: only the state bit set at reset

	// Priority of same-cycle events
	// Flags: ALU update beats a software write
	// Saturation: set event beats a software clear
	// Multiple save beats clear, clear beats block state
	// Mask: move write beats change-state write
	// Program counter: vector, then move, then core
	// Main stack: vector load beats a move write
	// Handler mode: always the main stack pointer
	// Allow output: one edge behind request and mask
	// Stacked word: one edge behind the stored fields
	// Stack and counter copies: one edge behind as well

	//--------------------------------------------------
	// Decode
	//--------------------------------------------------
	wire run = (state_q == crs_pkg::CRS_RUN);
	wire handler = (exnum_q != 9'h000);
	// stack choice by control bit in thread mode
	wire use_psp = i_sp_select && !handler;
	wire [31:0] sp_cur = use_psp ? psp_q : msp_q;
	wire wr = i_wr_en && run;
	wire wr_gpr = wr && (i_wr_sel <= `CRS_SEL_GPR_LAST);
	wire wr_msp = wr && ((i_wr_sel == `CRS_SEL_SP && !use_psp) ||
		i_wr_sel == `CRS_SEL_MSP);
	wire wr_psp = wr && ((i_wr_sel == `CRS_SEL_SP && use_psp) ||
		i_wr_sel == `CRS_SEL_PSP);
	wire wr_lr = wr && (i_wr_sel == `CRS_SEL_LR);
	wire wr_pc = wr && (i_wr_sel == `CRS_SEL_PC);
	// writable combinations carry the flags view
	wire wr_flags = wr && (i_wr_sel == `CRS_SEL_PSR ||
		i_wr_sel == `CRS_SEL_FLXN || i_wr_sel == `CRS_SEL_FLEX ||
		i_wr_sel == `CRS_SEL_FLAGS);
	// mask by move or by state change
	wire wr_mask = (wr && i_wr_sel == `CRS_SEL_MASK) || (i_cps_we && run);
	wire mask_val = (wr && i_wr_sel == `CRS_SEL_MASK) ?
		i_wr_data[0] : i_cps_val;
	wire [31:0] flags_word = {nzcv_q, sat_q, 27'h0000000};
	wire [31:0] num_word = {23'h000000, exnum_q};
	wire [31:0] exec_word = {5'h00, exec_hi_q[5:4], exec_t_q, 8'h00,
		exec_hi_q[3:0], exec_lo_q, 10'h000};

	// Read selection; execution view reads zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (i_rd_sel <= `CRS_SEL_GPR_LAST) begin
			rd_mux = gpr_q[i_rd_sel[3:0]];
		end else begin
			case (i_rd_sel)
				`CRS_SEL_SP: rd_mux = sp_cur;
				`CRS_SEL_LR: rd_mux = lr_q;
				`CRS_SEL_PC: rd_mux = pc_q;
				`CRS_SEL_MSP: rd_mux = msp_q;
				`CRS_SEL_PSP: rd_mux = psp_q;
				`CRS_SEL_MASK: rd_mux = {31'h00000000, mask_q};
				`CRS_SEL_PSR: rd_mux = flags_word | num_word;
				`CRS_SEL_EXNUM: rd_mux = num_word;
				`CRS_SEL_FLXN: rd_mux = flags_word | num_word;
				`CRS_SEL_FLEX: rd_mux = flags_word;
				`CRS_SEL_FLAGS: rd_mux = flags_word;
				`CRS_SEL_EXEC: rd_mux = 32'h00000000;
				`CRS_SEL_NUM: rd_mux = num_word;
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// Reset sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			crs_pkg::CRS_FETCH_SP:
				if (i_vec_valid) state_d = crs_pkg::CRS_FETCH_PC;
			crs_pkg::CRS_FETCH_PC:
				if (i_vec_valid) state_d = crs_pkg::CRS_RUN;
			crs_pkg::CRS_RUN: state_d = crs_pkg::CRS_RUN;
			default: state_d = crs_pkg::CRS_FETCH_SP;
		endcase
	end

	//--------------------------------------------------
	// General registers
	//--------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi <= 12; gi = gi + 1) begin : g_gpr
			always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
				if (!i_arst_n) gpr_q[gi] <= 32'h00000000;
				else if (wr_gpr && i_wr_sel[3:0] == 4'(gi))
					gpr_q[gi] <= i_wr_data;
			end
		end
	endgenerate

	//--------------------------------------------------
	// Stack, link and program counter
	//--------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= crs_pkg::CRS_FETCH_SP;
			msp_q <= 32'h00000000;
			psp_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			// main stack from first vector word
			if (state_q == crs_pkg::CRS_FETCH_SP && i_vec_valid)
				msp_q <= {i_vec_data[31:2], 2'h0};
			else if (wr_msp) msp_q <= {i_wr_data[31:2], 2'h0};
			if (wr_psp) psp_q <= {i_wr_data[31:2], 2'h0};
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lr_q <= `CRS_LR_RESET;
			pc_q <= 32'h00000000;
		end else begin
			if (wr_lr) lr_q <= i_wr_data;
			// bit zero forced clear on every load
			if (state_q == crs_pkg::CRS_FETCH_PC && i_vec_valid)
				pc_q <= {i_vec_data[31:1], 1'b0};
			else if (wr_pc) pc_q <= {i_wr_data[31:1], 1'b0};
			else if (i_pc_we && run) pc_q <= {i_pc_data[31:1], 1'b0};
		end
	end

	//--------------------------------------------------
	// Status word
	//--------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			nzcv_q <= 4'h0;
			sat_q <= 1'b0;
		end else begin
			if (i_flags_we) nzcv_q <= i_flags_nzcv;
			else if (wr_flags) nzcv_q <= i_wr_data[31:28];
			// sticky saturation, set wins over clear
			if (i_sat_event) sat_q <= 1'b1;
			else if (wr_flags) sat_q <= i_wr_data[`CRS_BIT_Q];
		end
	end

	// number only from exception logic, never software
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) exnum_q <= 9'h000;
		else if (i_exnum_we) exnum_q <= i_exnum;
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			exec_hi_q <= 6'h00;
			exec_lo_q <= 2'h0;
			exec_t_q <= 1'b1;
		end else begin
			exec_t_q <= 1'b1;
			if (i_ici_save) begin
				exec_hi_q <= {2'h0, i_ici_reg};
				exec_lo_q <= 2'h0;
			end else if (i_ici_clear) begin
				exec_hi_q <= 6'h00;
				exec_lo_q <= 2'h0;
			end else if (i_cond_we) begin
				// conditional block state, up to four
				exec_hi_q <= {i_cond_state[1:0], i_cond_state[7:4]};
				exec_lo_q <= i_cond_state[3:2];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) mask_q <= 1'b0;
		else if (wr_mask) mask_q <= mask_val;
	end

	//--------------------------------------------------
	// Registered outputs
	//--------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_vec_addr <= `CRS_MSP_VEC_ADDR;
			o_vec_req <= 1'b0;
			o_ready <= 1'b0;
			o_rd_data <= 32'h00000000;
			o_pc <= 32'h00000000;
			o_sp <= 32'h00000000;
			o_psr_stacked <= 32'h01000000;
			o_cfg_exc_allow <= 1'b0;
		end else begin
			o_vec_addr <= (state_d == crs_pkg::CRS_FETCH_SP) ?
				`CRS_MSP_VEC_ADDR : `CRS_PC_VEC_ADDR;
			o_vec_req <= (state_d != crs_pkg::CRS_RUN);
			o_ready <= (state_d == crs_pkg::CRS_RUN);
			if (i_rd_en) o_rd_data <= rd_mux;
			o_pc <= pc_q;
			o_sp <= sp_cur;
			o_psr_stacked <= flags_word | exec_word | num_word;
			o_cfg_exc_allow <= i_cfg_exc_req && !mask_q;
		end
	end

endmodule // crs_core_register_set
`default_nettype wire

/* File: crs_defines.svh */
// Purpose: Constants for the core register set
// Assumes: 32-bit data path
// Notes: Offsets are field positions within the status word
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
`define CRS_MSP_VEC_ADDR 32'h00000000
`define CRS_PC_VEC_ADDR 32'h00000004
`define CRS_LR_RESET 32'h0FFFFFFF
`define CRS_BIT_N 31
`define CRS_BIT_Z 30
`define CRS_BIT_C 29
`define CRS_BIT_V 28
`define CRS_BIT_Q 27
`define CRS_BIT_T 24
`define CRS_FLAGS_MASK 32'hF8000000
`define CRS_EXEC_MASK 32'h0700FC00
`define CRS_NUM_MASK 32'h000001FF
`define CRS_SEL_GPR_LAST 5'h0C
`define CRS_SEL_SP 5'h0D
`define CRS_SEL_LR 5'h0E
`define CRS_SEL_PC 5'h0F
`define CRS_SEL_MSP 5'h10
`define CRS_SEL_PSP 5'h11
`define CRS_SEL_MASK 5'h12
`define CRS_SEL_PSR 5'h13
`define CRS_SEL_EXNUM 5'h14
`define CRS_SEL_FLXN 5'h15
`define CRS_SEL_FLEX 5'h16
`define CRS_SEL_FLAGS 5'h17
`define CRS_SEL_EXEC 5'h18
`define CRS_SEL_NUM 5'h19
`endif

/* File: crs_pkg.sv */
// Purpose: Types for the core register set
// Assumes: Nothing
// Notes: Reset sequencer states in Gray order
package crs_pkg;
	typedef enum logic [1:0] {
		CRS_FETCH_SP = 2'h0,
		CRS_FETCH_PC = 2'h1,
		CRS_RUN = 2'h3
	} crs_state_t;
endpackage

/* File: crs_core_register_set_props.sv */
// Purpose: Port checks for the register set
// Assumes: One clock domain
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module crs_set_props (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_vec_valid,
	input wire logic i_rd_en,
	input wire logic [4:0] i_rd_sel,
	input wire logic i_flags_we,
	input wire logic [3:0] i_flags_nzcv,
	input wire logic i_sat_event,
	input wire logic i_cfg_exc_req,
	input wire logic [31:0] o_vec_addr,
	input wire logic o_vec_req,
	input wire logic o_ready,
	input wire logic [31:0] o_rd_data,
	input wire logic [31:0] o_pc,
	input wire logic [31:0] o_psr_stacked,
	input wire logic o_cfg_exc_allow
);
// ---
// Checks
// ---
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (!i_arst_n);
a_pc_bit_zero: assert property (!o_pc[0])
	else $error("pc bit0 set");
a_vec_first: assert property ($rose(o_vec_req) |-> o_vec_addr == 32'h0)
	else $error("first vector addr");
a_vec_second: assert property (o_vec_req && i_vec_valid &&
	o_vec_addr == 32'h0 |=> o_vec_addr == 32'h4) else $error("second addr");
a_ready_boot: assert property (o_vec_req && i_vec_valid &&
	o_vec_addr == 32'h4 |=> ##[0:1] o_ready) else $error("no ready");
a_flags_load: assert property (i_flags_we |=> ##1
	o_psr_stacked[31:28] == $past(i_flags_nzcv, 2)) else $error("flags");
a_sat_set: assert property (i_sat_event |=> ##1 o_psr_stacked[27])
	else $error("sat flag");
a_exec_zero: assert property (i_rd_en && i_rd_sel == 5'h18 |=>
	o_rd_data == 32'h0) else $error("exec read");
a_state_bit: assert property (o_psr_stacked[24])
	else $error("state bit");
a_resv_zero: assert property (o_psr_stacked[23:16] == 8'h00 &&
	!o_psr_stacked[9]) else $error("reserved bits");
a_allow_cause: assert property (o_cfg_exc_allow |->
	$past(i_cfg_exc_req)) else $error("allow without req");
endmodule // crs_set_props
bind crs_core_register_set crs_set_props u_props (.i_clk_sys, .i_arst_n,
	.i_vec_valid, .i_rd_en, .i_rd_sel, .i_flags_we, .i_flags_nzcv,
	.i_sat_event, .i_cfg_exc_req, .o_vec_addr, .o_vec_req, .o_ready,
	.o_rd_data, .o_pc, .o_psr_stacked, .o_cfg_exc_allow);
`default_nettype wire

/* File: crs_core_register_set_tb_top.sv */
// Purpose: Self-checking bench for the register set
// Assumes: Vector words answered by the bench
// Notes: Selector codes as in the hand-over
`timescale 1ns/1ps
`default_nettype none
`define CRS_CHK(n, e, g) chk(n, e, g)
module crs_core_register_set_tb_top;
logic i_clk_sys, i_arst_n, i_vec_valid, i_sp_select, i_rd_en, i_wr_en;
logic i_pc_we, i_flags_we, i_sat_event, i_exnum_we, i_ici_save;
logic i_ici_clear, i_cond_we, i_cps_we, i_cps_val, i_cfg_exc_req;
logic [31:0] i_vec_data, i_wr_data, i_pc_data;
logic [4:0] i_rd_sel, i_wr_sel;
logic [3:0] i_flags_nzcv, i_ici_reg;
logic [8:0] i_exnum;
logic [7:0] i_cond_state;
logic [31:0] o_vec_addr, o_rd_data, o_pc, o_sp, o_psr_stacked;
logic o_vec_req, o_ready, o_cfg_exc_allow;
int mismatches, samples_checked;
crs_core_register_set uut (.*);
// ---
// Helpers
// ---
task automatic chk(string n, logic [31:0] e, logic [31:0] g);
	samples_checked++;
	if (g !== e) begin
		mismatches++;
		$display("ERROR %s exp %h got %h", n, e, g);
	end
endtask
task automatic give_verdict();
	$display("checks %0d mismatches %0d", samples_checked, mismatches);
	if (mismatches == 0 && samples_checked > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task automatic tick(int n);
	repeat (n) @(posedge i_clk_sys);
endtask
task automatic await(bit rdy);
	int n = 0;
	while ((rdy ? o_ready : o_vec_req) !== 1'b1) begin
		tick(1);
		n++;
		if (n > 50) begin
			mismatches++;
			give_verdict();
		end
	end
endtask
task automatic wr(logic [4:0] s, logic [31:0] d);
	tick(1);
	i_wr_en <= 1'b1;
	i_wr_sel <= s;
	i_wr_data <= d;
	tick(1);
	i_wr_en <= 1'b0;
endtask
task automatic rd(logic [4:0] s, logic [31:0] e);
	tick(1);
	i_rd_en <= 1'b1;
	i_rd_sel <= s;
	tick(1);
	i_rd_en <= 1'b0;
	#1 `CRS_CHK($sformatf("sel %h", s), e, o_rd_data);
endtask
task automatic vec(logic [31:0] w);
	tick(1);
	i_vec_data <= w;
	i_vec_valid <= 1'b1;
	tick(1);
	i_vec_valid <= 1'b0;
	#1;
endtask
// ---
// Scenarios
// ---
task automatic t_boot();
	wr(5'h00, 32'h12345678);
	await(1'b0);
	`CRS_CHK("vaddr", 32'h0, o_vec_addr);
	vec(32'h20000403);
	`CRS_CHK("vaddr", 32'h4, o_vec_addr);
	vec(32'h00000101);
	await(1'b1);
	rd(5'h00, 32'h0);
	rd(5'h10, 32'h20000400);
	rd(5'h0F, 32'h00000100);
	rd(5'h0E, 32'h0FFFFFFF);
endtask
task automatic t_gpr();
	for (int i = 0; i < 13; i++)
		wr(5'(i), {8'hA5, 8'(i), 16'hC3E1});
	for (int i = 0; i < 13; i++)
		rd(5'(i), {8'hA5, 8'(i), 16'hC3E1});
	tick(1);
	i_pc_we <= 1'b1;
	i_pc_data <= 32'h00002003;
	tick(1);
	i_pc_we <= 1'b0;
	rd(5'h0F, 32'h00002002);
endtask
task automatic t_stack();
	wr(5'h11, 32'h30000008);
	rd(5'h0D, 32'h20000400);
	tick(1);
	i_sp_select <= 1'b1;
	rd(5'h0D, 32'h30000008);
	`CRS_CHK("sp", 32'h30000008, o_sp);
endtask
task automatic t_psr();
	tick(1);
	i_flags_we <= 1'b1;
	i_flags_nzcv <= 4'hA;
	i_sat_event <= 1'b1;
	i_exnum_we <= 1'b1;
	i_exnum <= 9'h00B;
	tick(1);
	{i_flags_we, i_sat_event, i_exnum_we} <= 3'h0;
	rd(5'h17, 32'hA8000000);
	wr(5'h17, 32'h50000000);
	rd(5'h17, 32'h50000000);
	rd(5'h19, 32'h0000000B);
	rd(5'h0D, 32'h20000400);
	wr(5'h15, 32'hFFFFFFFF);
	rd(5'h15, 32'hF800000B);
	wr(5'h16, 32'hFFFFFFFF);
	rd(5'h16, 32'hF8000000);
	wr(5'h13, 32'h0);
	rd(5'h13, 32'h0000000B);
	rd(5'h14, 32'h0000000B);
	rd(5'h1F, 32'h0);
endtask
task automatic t_exec();
	tick(1);
	i_cond_we <= 1'b1;
	i_cond_state <= 8'hA6;
	tick(1);
	i_cond_we <= 1'b0;
	tick(1);
	#1 `CRS_CHK("cond", 32'h0500A400, o_psr_stacked & 32'h0700FC00);
	rd(5'h18, 32'h0);
	tick(1);
	i_ici_save <= 1'b1;
	i_ici_reg <= 4'h5;
	tick(1);
	i_ici_save <= 1'b0;
	tick(1);
	#1 `CRS_CHK("ici", 32'h01005000, o_psr_stacked & 32'h0700FC00);
	tick(1);
	i_ici_clear <= 1'b1;
	tick(1);
	i_ici_clear <= 1'b0;
endtask
task automatic t_mask();
	tick(1);
	i_cfg_exc_req <= 1'b1;
	i_cps_we <= 1'b1;
	i_cps_val <= 1'b1;
	tick(1);
	i_cps_we <= 1'b0;
	tick(2);
	#1 `CRS_CHK("allow", 32'h0, 32'(o_cfg_exc_allow));
	rd(5'h12, 32'h1);
	wr(5'h12, 32'hFFFFFFFE);
	rd(5'h12, 32'h0);
	`CRS_CHK("allow", 32'h1, 32'(o_cfg_exc_allow));
endtask
// Clock source
initial begin
	i_clk_sys = 1'b0;
	forever #5 i_clk_sys = ~i_clk_sys;
end
// Main sequence
initial begin
	{i_arst_n, i_vec_valid, i_sp_select, i_rd_en, i_wr_en, i_pc_we,
		i_flags_we, i_sat_event, i_exnum_we, i_ici_save, i_ici_clear,
		i_cond_we, i_cps_we, i_cps_val, i_cfg_exc_req, i_vec_data,
		i_wr_data, i_pc_data, i_rd_sel, i_wr_sel, i_flags_nzcv,
		i_ici_reg, i_exnum, i_cond_state} = '0;
	tick(12);
	i_arst_n <= 1'b1;
	t_boot();
	t_gpr();
	t_stack();
	t_psr();
	t_exec();
	t_mask();
	give_verdict();
end
endmodule // crs_core_register_set_tb_top
`default_nettype wire
